// ### logic/moh_consts.svh
// Constants of the CAN message object handler: offsets, field positions, timing
`ifndef MOH_CONSTS_SVH
`define MOH_CONSTS_SVH

// ==================================================
// Timing
`define MOH_CLK_FREQ_MHZ 25
`define MOH_BIT_TIME_NS 1000
`define MOH_BIT_CYCLES ((`MOH_BIT_TIME_NS * `MOH_CLK_FREQ_MHZ + 999) / 1000)
`define MOH_IDLE_BITS 11
`define MOH_NUM_OBJ 14

// ==================================================
// Register map (byte addresses; object base is a 16-byte slot, object registers are word offsets)
`define MOH_ADR_CTRL_STAT 9'h000
`define MOH_ADR_IDENT 9'h004
`define MOH_OBJ_BASE_SLOT 5'h04
`define MOH_OBJ_MCR 2'h0
`define MOH_OBJ_CFG 2'h1
`define MOH_OBJ_DLO 2'h2
`define MOH_OBJ_DHI 2'h3

// ==================================================
// Control byte (bits 7:0) and status byte (bits 15:8)
`define MOH_CTL_INIT 0
`define MOH_CTL_GIE 1
`define MOH_CTL_SCIE 2
`define MOH_CTL_ERIE 3
`define MOH_CTL_CFGEN 6
`define MOH_CTL_RESET 8'h01
`define MOH_STAT_TXSUC 3
`define MOH_STAT_RXSUC 4
`define MOH_STAT_RESET 8'h00

// ==================================================
// Message control word: two-bit pairs, low bit of each pair
`define MOH_MCR_PEND 0
`define MOH_MCR_RXEN 2
`define MOH_MCR_TXEN 4
`define MOH_MCR_MSGVAL 6
`define MOH_MCR_NEWD 8
`define MOH_MCR_UPD 10
`define MOH_MCR_TREQ 12
`define MOH_MCR_RPEND 14
`define MOH_PAIR_SET 2'b10
`define MOH_PAIR_CLR 2'b01

// ==================================================
// Object configuration word
`define MOH_CFG_ID_LSB 0
`define MOH_CFG_DLC_LSB 12
`define MOH_CFG_DIR 16

// ==================================================
// Interrupt identifier codes
`define MOH_IDENT_NONE 8'h00
`define MOH_IDENT_STATUS 8'h01
`define MOH_IDENT_OBJ_OFS 8'h02

`endif

// ### logic/moh_message_object_handler.sv
// CAN message object handler with Wishbone register slave
//
// Summary of operation
// - Stay off bus until 11 recessive bits
// - Clear cpu update plus set request on transmit object: send, clear new data
// - Transmit request alone sends stored frame
// - Acked send clears request, pending; sets success
// - Transmit interrupt when enabled after success
// - Request on receive object sends remote frame
// - Answer to remote request sets new data
// - Remote frame into transmit object stores length only
// - Remote frame sets request, pending; auto answer
// - Remote frame raises receive interrupt when enabled
// - Data frame stored when new data clear
// - Stored data frame raises receive interrupt when enabled
// - Status update shows identifier 01 when enabled
// - Object n pending shows identifier n plus two
// - Clearing pending shows next source or 00h
// - Interrupt line high while identifier nonzero
// - Read of status byte clears status identifier
// - Lowest identifier value wins priority
// - Init end and enables in one write
// - Direction one transmits data, zero receives
// - Receive object flags message lost on overrun
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/100ps

`include "moh_consts.svh"

module moh_message_object_handler #(
  parameter int NUM_OBJ = `MOH_NUM_OBJ,
  parameter int BIT_CYCLES = `MOH_BIT_CYCLES,
  parameter int IDLE_BITS = `MOH_IDLE_BITS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic can_rx_pin,
  output logic bus_on,
  output logic tx_valid,
  output moh_pkg::moh_frame_t tx_frame,
  input wire logic tx_done,
  input wire logic tx_acked,
  input wire logic rx_valid,
  input wire moh_pkg::moh_frame_t rx_frame,
  output logic irq
);

  localparam int CW = $clog2(BIT_CYCLES + 1);

  // ==================================================
  // Reset release and pin synchroniser
  logic rst_s1_ff;
  logic rst_n_ff;
  logic rx_s1_ff;
  logic rx_s2_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= can_rx_pin;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // ==================================================
  // State declarations
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic stat_int_ff;
  logic nxt_stat_int;
  moh_pkg::moh_obj_t obj_ff [1:NUM_OBJ];
  moh_pkg::moh_obj_t nxt_obj [1:NUM_OBJ];
  moh_pkg::moh_tx_state_t tx_state_ff;
  moh_pkg::moh_tx_state_t nxt_tx_state;
  logic [4:0] tx_idx_ff;
  logic [4:0] nxt_tx_idx;
  moh_pkg::moh_frame_t tx_frame_ff;
  moh_pkg::moh_frame_t nxt_tx_frame;
  logic [7:0] ident_ff;
  logic [7:0] nxt_ident;
  logic irq_ff;
  logic ack_ff;
  logic [31:0] dat_o_ff;
  logic [31:0] rd_data;
  logic [CW-1:0] cyc_cnt_ff;
  logic [CW-1:0] nxt_cyc_cnt;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic bus_on_ff;
  logic nxt_bus_on;

  // ==================================================
  // Bus idle detection after initialization
  always_comb begin
    nxt_cyc_cnt = cyc_cnt_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_bus_on = bus_on_ff;
    if (ctl_ff[`MOH_CTL_INIT]) begin
      nxt_cyc_cnt = '0;
      nxt_bit_cnt = '0;
      nxt_bus_on = 1'b0;
    end else if (!bus_on_ff) begin
      if (!rx_s2_ff) begin
        nxt_cyc_cnt = '0;
        nxt_bit_cnt = '0;
      end else if (cyc_cnt_ff == CW'(BIT_CYCLES - 1)) begin
        nxt_cyc_cnt = '0;
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == 4'(IDLE_BITS - 1)) begin
          nxt_bus_on = 1'b1;
        end
      end else begin
        nxt_cyc_cnt = cyc_cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cyc_cnt_ff <= '0;
      bit_cnt_ff <= '0;
      bus_on_ff <= 1'b0;
    end else begin
      cyc_cnt_ff <= nxt_cyc_cnt;
      bit_cnt_ff <= nxt_bit_cnt;
      bus_on_ff <= nxt_bus_on;
    end
  end

  // ==================================================
  // Address decode and per-object candidates
  logic req;
  logic [4:0] slot;
  logic [4:0] sel_obj;
  logic obj_hit;
  logic [NUM_OBJ:1] tx_cand;
  logic [NUM_OBJ:1] rx_match;
  logic [NUM_OBJ:1] int_cand;
  logic [4:0] tx_pick;
  logic [4:0] rx_pick;
  logic [4:0] int_pick;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign slot = wb_adr_i[8:4];
  assign sel_obj = slot - `MOH_OBJ_BASE_SLOT;
  assign obj_hit = (slot > `MOH_OBJ_BASE_SLOT) && (sel_obj <= 5'(NUM_OBJ));

  genvar gi;
  generate
    for (gi = 1; gi <= NUM_OBJ; gi++) begin : g_obj
      // Writer holds off a transmit object while it updates the data
      assign tx_cand[gi] = obj_ff[gi].msgval & obj_ff[gi].transmit_request &
        ~(obj_ff[gi].dir & obj_ff[gi].cpu_update_in_progress);
      assign rx_match[gi] = obj_ff[gi].msgval & (obj_ff[gi].id == rx_frame.id);
      assign int_cand[gi] = obj_ff[gi].interrupt_pending;
    end
  endgenerate

  function automatic logic [4:0] lowest(input logic [NUM_OBJ:1] v);
    logic [4:0] r;
    r = '0;
    for (int i = NUM_OBJ; i >= 1; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic pair_apply(input logic cur, input logic [1:0] code);
    logic r;
    r = cur;
    if (code == `MOH_PAIR_SET) begin
      r = 1'b1;
    end else if (code == `MOH_PAIR_CLR) begin
      r = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign tx_pick = lowest(tx_cand);
  assign rx_pick = lowest(rx_match);
  assign int_pick = lowest(int_cand);

  // ==================================================
  // Message objects, control, status and transmit engine
  always_comb begin
    logic [15:0] w;
    logic [31:0] cfg;
    logic stat_evt;
    logic gie;
    w = wb_dat_i[15:0];
    cfg = '0;
    stat_evt = 1'b0;
    gie = ctl_ff[`MOH_CTL_GIE];
    nxt_ctl = ctl_ff;
    nxt_stat = stat_ff;
    nxt_stat_int = stat_int_ff;
    nxt_obj = obj_ff;
    nxt_tx_state = tx_state_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx_frame = tx_frame_ff;

    // Software writes come first so that hardware sets below win
    if (req && wb_we_i) begin
      if (wb_adr_i == `MOH_ADR_CTRL_STAT) begin
        if (wb_sel_i[0]) begin
          nxt_ctl = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          nxt_stat = wb_dat_i[15:8];
        end
      end else if (obj_hit) begin
        unique case (wb_adr_i[3:2])
          `MOH_OBJ_MCR: begin
            if (wb_sel_i[0]) begin
              nxt_obj[sel_obj].interrupt_pending = pair_apply(
                obj_ff[sel_obj].interrupt_pending, w[`MOH_MCR_PEND +: 2]);
              nxt_obj[sel_obj].receive_interrupt_enable = pair_apply(
                obj_ff[sel_obj].receive_interrupt_enable, w[`MOH_MCR_RXEN +: 2]);
              nxt_obj[sel_obj].transmit_interrupt_enable = pair_apply(
                obj_ff[sel_obj].transmit_interrupt_enable, w[`MOH_MCR_TXEN +: 2]);
              nxt_obj[sel_obj].msgval = pair_apply(obj_ff[sel_obj].msgval,
                w[`MOH_MCR_MSGVAL +: 2]);
            end
            if (wb_sel_i[1]) begin
              nxt_obj[sel_obj].new_data_flag = pair_apply(obj_ff[sel_obj].new_data_flag,
                w[`MOH_MCR_NEWD +: 2]);
              nxt_obj[sel_obj].cpu_update_in_progress = pair_apply(
                obj_ff[sel_obj].cpu_update_in_progress, w[`MOH_MCR_UPD +: 2]);
              nxt_obj[sel_obj].transmit_request = pair_apply(
                obj_ff[sel_obj].transmit_request, w[`MOH_MCR_TREQ +: 2]);
              nxt_obj[sel_obj].remote_pending = pair_apply(obj_ff[sel_obj].remote_pending,
                w[`MOH_MCR_RPEND +: 2]);
              if (obj_ff[sel_obj].dir && w[`MOH_MCR_UPD +: 2] == `MOH_PAIR_CLR &&
                  w[`MOH_MCR_TREQ +: 2] == `MOH_PAIR_SET) begin
                nxt_obj[sel_obj].new_data_flag = 1'b0;
              end
            end
          end
          `MOH_OBJ_CFG: begin
            cfg = merge({15'h0000, obj_ff[sel_obj].dir, obj_ff[sel_obj].dlc, 1'b0,
              obj_ff[sel_obj].id}, wb_dat_i, wb_sel_i);
            nxt_obj[sel_obj].id = cfg[`MOH_CFG_ID_LSB +: 11];
            nxt_obj[sel_obj].dlc = cfg[`MOH_CFG_DLC_LSB +: 4];
            nxt_obj[sel_obj].dir = cfg[`MOH_CFG_DIR];
          end
          `MOH_OBJ_DLO: begin
            nxt_obj[sel_obj].data[31:0] = merge(obj_ff[sel_obj].data[31:0], wb_dat_i,
              wb_sel_i);
          end
          `MOH_OBJ_DHI: begin
            nxt_obj[sel_obj].data[63:32] = merge(obj_ff[sel_obj].data[63:32], wb_dat_i,
              wb_sel_i);
          end
        endcase
      end
    end

    // Reading the status byte retires the status identifier
    if (req && !wb_we_i && wb_adr_i == `MOH_ADR_CTRL_STAT && wb_sel_i[1]) begin
      nxt_stat_int = 1'b0;
    end

    // Transmit engine
    unique case (tx_state_ff)
      moh_pkg::tx_idle: begin
        if (bus_on_ff && !ctl_ff[`MOH_CTL_INIT] && tx_pick != 5'h00) begin
          nxt_tx_idx = tx_pick;
          nxt_tx_frame.id = obj_ff[tx_pick].id;
          nxt_tx_frame.rtr = ~obj_ff[tx_pick].dir;
          nxt_tx_frame.dlc = obj_ff[tx_pick].dlc;
          nxt_tx_frame.data = obj_ff[tx_pick].data;
          nxt_tx_state = moh_pkg::tx_busy;
        end
      end
      moh_pkg::tx_busy: begin
        if (tx_done) begin
          nxt_tx_state = moh_pkg::tx_idle;
          if (tx_acked && !nxt_obj[tx_idx_ff].new_data_flag) begin
            nxt_obj[tx_idx_ff].transmit_request = 1'b0;
            nxt_obj[tx_idx_ff].remote_pending = 1'b0;
            nxt_stat[`MOH_STAT_TXSUC] = 1'b1;
            stat_evt = 1'b1;
            if (gie && obj_ff[tx_idx_ff].transmit_interrupt_enable) begin
              nxt_obj[tx_idx_ff].interrupt_pending = 1'b1;
            end
          end
        end
      end
    endcase

    // Frame reception
    if (rx_valid && bus_on_ff && rx_pick != 5'h00) begin
      if (rx_frame.rtr && obj_ff[rx_pick].dir) begin
        nxt_obj[rx_pick].dlc = rx_frame.dlc;
        nxt_obj[rx_pick].transmit_request = 1'b1;
        nxt_obj[rx_pick].remote_pending = 1'b1;
        nxt_stat[`MOH_STAT_RXSUC] = 1'b1;
        stat_evt = 1'b1;
        if (gie && obj_ff[rx_pick].receive_interrupt_enable) begin
          nxt_obj[rx_pick].interrupt_pending = 1'b1;
        end
      end else if (!rx_frame.rtr && !obj_ff[rx_pick].dir) begin
        if (!obj_ff[rx_pick].new_data_flag) begin
          nxt_obj[rx_pick].new_data_flag = 1'b1;
          nxt_obj[rx_pick].id = rx_frame.id;
          nxt_obj[rx_pick].dlc = rx_frame.dlc;
          nxt_obj[rx_pick].data = rx_frame.data;
        end else begin
          nxt_obj[rx_pick].cpu_update_in_progress = 1'b1;
        end
        nxt_stat[`MOH_STAT_RXSUC] = 1'b1;
        stat_evt = 1'b1;
        if (gie && obj_ff[rx_pick].receive_interrupt_enable) begin
          nxt_obj[rx_pick].interrupt_pending = 1'b1;
        end
      end
    end

    if (stat_evt && gie && ctl_ff[`MOH_CTL_SCIE]) begin
      nxt_stat_int = 1'b1;
    end

    // Priority: status first, then lowest object number
    if (stat_int_ff) begin
      nxt_ident = `MOH_IDENT_STATUS;
    end else if (int_pick != 5'h00) begin
      nxt_ident = `MOH_IDENT_OBJ_OFS + 8'(int_pick);
    end else begin
      nxt_ident = `MOH_IDENT_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctl_ff <= `MOH_CTL_RESET;
      stat_ff <= `MOH_STAT_RESET;
      stat_int_ff <= 1'b0;
      tx_state_ff <= moh_pkg::tx_idle;
      tx_idx_ff <= '0;
      tx_frame_ff <= '0;
      ident_ff <= `MOH_IDENT_NONE;
      irq_ff <= 1'b0;
      for (int i = 1; i <= NUM_OBJ; i++) begin
        obj_ff[i] <= '0;
      end
    end else begin
      ctl_ff <= nxt_ctl;
      stat_ff <= nxt_stat;
      stat_int_ff <= nxt_stat_int;
      tx_state_ff <= nxt_tx_state;
      tx_idx_ff <= nxt_tx_idx;
      tx_frame_ff <= nxt_tx_frame;
      ident_ff <= nxt_ident;
      irq_ff <= (nxt_ident != `MOH_IDENT_NONE);
      for (int i = 1; i <= NUM_OBJ; i++) begin
        obj_ff[i] <= nxt_obj[i];
      end
    end
  end

  // ==================================================
  // Wishbone read mux and acknowledge
  always_comb begin
    rd_data = '0;
    if (wb_adr_i == `MOH_ADR_CTRL_STAT) begin
      rd_data = {16'h0000, stat_ff, ctl_ff};
    end else if (wb_adr_i == `MOH_ADR_IDENT) begin
      rd_data = {24'h00_0000, ident_ff};
    end else if (obj_hit) begin
      unique case (wb_adr_i[3:2])
        `MOH_OBJ_MCR: begin
          rd_data = {16'h0000,
            obj_ff[sel_obj].remote_pending, ~obj_ff[sel_obj].remote_pending,
            obj_ff[sel_obj].transmit_request, ~obj_ff[sel_obj].transmit_request,
            obj_ff[sel_obj].cpu_update_in_progress,
            ~obj_ff[sel_obj].cpu_update_in_progress,
            obj_ff[sel_obj].new_data_flag, ~obj_ff[sel_obj].new_data_flag,
            obj_ff[sel_obj].msgval, ~obj_ff[sel_obj].msgval,
            obj_ff[sel_obj].transmit_interrupt_enable,
            ~obj_ff[sel_obj].transmit_interrupt_enable,
            obj_ff[sel_obj].receive_interrupt_enable,
            ~obj_ff[sel_obj].receive_interrupt_enable,
            obj_ff[sel_obj].interrupt_pending,
            ~obj_ff[sel_obj].interrupt_pending};
        end
        `MOH_OBJ_CFG: begin
          rd_data = {15'h0000, obj_ff[sel_obj].dir, obj_ff[sel_obj].dlc, 1'b0,
            obj_ff[sel_obj].id};
        end
        `MOH_OBJ_DLO: begin
          rd_data = obj_ff[sel_obj].data[31:0];
        end
        `MOH_OBJ_DHI: begin
          rd_data = obj_ff[sel_obj].data[63:32];
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_ff <= 1'b0;
      dat_o_ff <= '0;
    end else begin
      ack_ff <= req;
      dat_o_ff <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_o_ff;
  assign bus_on = bus_on_ff;
  assign tx_valid = (tx_state_ff == moh_pkg::tx_busy);
  assign tx_frame = tx_frame_ff;
  assign irq = irq_ff;

endmodule

// ### logic/moh_pkg.sv
// Types of the CAN message object handler
package moh_pkg;

  // ==================================================
  // Frame as exchanged with the protocol engine
  typedef struct packed {
    logic [10:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } moh_frame_t;

  // ==================================================
  // One message object
  typedef struct packed {
    logic interrupt_pending;
    logic receive_interrupt_enable;
    logic transmit_interrupt_enable;
    logic msgval;
    logic new_data_flag;
    logic cpu_update_in_progress;
    logic transmit_request;
    logic remote_pending;
    logic dir;
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } moh_obj_t;

  typedef enum logic {
    tx_idle = 1'b0,
    tx_busy = 1'b1
  } moh_tx_state_t;

endpackage

// ### verif/moh_can_node.sv
// Behavioural model of the far CAN nodes and protocol engine
`timescale 1ns/100ps

module moh_can_node (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire moh_pkg::moh_frame_t tx_frame,
  input wire logic ack_en,
  input wire logic [3:0] delay,
  output logic tx_done,
  output logic tx_acked,
  output logic can_rx_pin,
  output logic rx_valid,
  output moh_pkg::moh_frame_t rx_frame
);
  logic [3:0] cnt;
  logic rx_busy;
  int n_tx;
  int n_ok;
  moh_pkg::moh_frame_t last_tx;
  initial begin
    rx_valid = 1'b0;
    rx_busy = 1'b0;
    rx_frame = '0;
  end
  // Recessive between frames, dominant bits while a frame is on the wire
  assign can_rx_pin = ~(rx_busy | (tx_valid & cnt[0]));
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      tx_done <= 1'b0;
      tx_acked <= 1'b0;
      n_tx <= 0;
      n_ok <= 0;
    end else begin
      tx_done <= 1'b0;
      tx_acked <= ~tx_acked;
      if (tx_valid && !tx_done) begin
        cnt <= cnt + 4'h1;
        if (cnt == delay) begin
          cnt <= 4'h0;
          tx_done <= 1'b1;
          tx_acked <= ack_en;
          last_tx <= tx_frame;
          n_tx <= n_tx + 1;
          n_ok <= n_ok + (ack_en ? 1 : 0);
        end
      end
    end
  end
  // Frame from another node, answers to remote requests among them
  task automatic send(input moh_pkg::moh_frame_t f);
    rx_busy <= 1'b1;
    repeat (4) @(posedge mclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
    rx_busy <= 1'b0;
  endtask
endmodule

// ### verif/moh_message_object_handler_monitor.sv
// Port checker of the CAN message object handler
`timescale 1ns/100ps

`include "moh_consts.svh"

module moh_message_object_handler_monitor #(
  parameter int BIT_CYCLES = 2,
  parameter int IDLE_BITS = 11
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [8:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic can_rx_pin,
  input wire logic bus_on,
  input wire logic tx_valid,
  input wire moh_pkg::moh_frame_t tx_frame,
  input wire logic tx_done,
  input wire logic irq
);
  // ==================================================
  // Length of the current recessive run on the pin
  int run_ff;
  int nxt_run;
  always_comb begin
    nxt_run = run_ff;
    if (!can_rx_pin) begin
      nxt_run = 0;
    end else if (run_ff < 1000) begin
      nxt_run = run_ff + 1;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  // ==================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence id_rd_s;
    req_s ##0 (!wb_we_i && wb_adr_i == `MOH_ADR_IDENT);
  endsequence
  ack_after_req_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  idle_run_a: assert property (
    $rose(bus_on) |-> run_ff >= IDLE_BITS * BIT_CYCLES)
    else $error("bus on before idle run");
  tx_after_on_a: assert property ($rose(tx_valid) |-> $past(bus_on))
    else $error("frame offered while off bus");
  tx_hold_a: assert property (
    tx_valid && !tx_done |=> tx_valid && $stable(tx_frame))
    else $error("offered frame not held");
  tx_release_a: assert property (tx_valid && tx_done |=> !tx_valid)
    else $error("offer not dropped after done");
  irq_ident_a: assert property (
    id_rd_s |=> $past(irq) == (wb_dat_o[7:0] != 8'h00))
    else $error("irq differs from identifier");
endmodule

// ### verif/moh_message_object_handler_tb.sv
// Testbench of the CAN message object handler
`timescale 1ns/100ps

`include "moh_consts.svh"

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module moh_message_object_handler_tb;
  logic mclk, nrst, wb_we, wb_cyc, wb_stb, ack_en;
  logic [8:0] wb_adr;
  logic [31:0] wb_dat, q, wb_dat_o;
  logic [3:0] wb_sel, delay;
  logic [7:0] st;
  logic wb_ack_o, can_rx_pin, bus_on, tx_valid, tx_done, tx_acked, rx_valid, irq;
  moh_pkg::moh_frame_t tx_frame, rx_frame;
  int n_fail = 0;
  int tests_run = 0;
  int i;
  localparam logic [63:0] D1 = 64'h0000_0000_3322_1100;

  moh_message_object_handler #(.BIT_CYCLES(2)) DUT (.mclk, .nrst, .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_dat_o, .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o, .can_rx_pin, .bus_on, .tx_valid, .tx_frame, .tx_done,
    .tx_acked, .rx_valid, .rx_frame, .irq);
  moh_can_node NODE (.mclk, .nrst, .tx_valid, .tx_frame, .ack_en, .delay, .tx_done,
    .tx_acked, .can_rx_pin, .rx_valid, .rx_frame);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle; read data lands in q
  task automatic wb(input logic [8:0] a, input logic we, input logic [31:0] d,
    input logic [3:0] s);
    int k;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) begin
      @(posedge mclk);
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (k == 20) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic wait_ok(input int n);
    int k;
    for (k = 0; k < 400 && NODE.n_ok < n; k++) begin
      @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    if (k == 400) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic ident(input logic [7:0] e);
    wb(`MOH_ADR_IDENT, 1'b0, 32'h0000_0000, 4'h1);
    `CHK("ident", e, q[7:0])
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    {wb_we, wb_cyc, wb_stb, ack_en} = 4'h0;
    wb_adr = 9'h000;
    wb_dat = 32'h0000_0000;
    wb_sel = 4'h0;
    delay = 4'h3;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(9'h000, 1'b0, 32'h0000_0000, 4'h1);
    `CHK("ctrl", 8'h01, q[7:0])
    wb(9'h1F0, 1'b1, 32'hFFFF_FFFF, 4'hF);
    wb(9'h1F0, 1'b0, 32'h0000_0000, 4'hF);
    `CHK("unmapped", 32'h0000_0000, q)
    // Transmit object 1 and receive object 2
    wb(9'h054, 1'b1, 32'h0001_4123, 4'hF);
    wb(9'h05C, 1'b1, 32'h0000_0000, 4'hF);
    wb(9'h050, 1'b1, 32'h0000_59A9, 4'h3);
    wb(9'h064, 1'b1, 32'h0000_02A5, 4'hF);
    wb(9'h060, 1'b1, 32'h0000_5599, 4'h3);
    repeat (40) @(posedge mclk);
    `CHK("bus_on init", 1'b0, bus_on)
    wb(9'h000, 1'b1, 32'h0000_000E, 4'h1);
    for (i = 0; i < 200 && bus_on !== 1'b1; i++) begin
      @(posedge mclk);
    end
    `CHK("bus_on", 1'b1, bus_on)
    // Data frame: update handshake, refused acknowledge, then success
    wb(9'h050, 1'b1, 32'h0000_FAFF, 4'h3);
    wb(9'h058, 1'b1, 32'h3322_1100, 4'hF);
    wb(9'h050, 1'b1, 32'h0000_E7FF, 4'h3);
    repeat (60) @(posedge mclk);
    wb(9'h050, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("request nack", 2'b10, q[13:12])
    `CHK("retry", 1'b1, NODE.n_tx > 1)
    ack_en <= 1'b1;
    wait_ok(1);
    wb(9'h050, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("mcr1", 32'h0000_55AA, q)
    `CHK("frame", {11'h123, 1'b0, 4'h4, D1}, NODE.last_tx)
    wb(9'h050, 1'b1, 32'h0000_EFFF, 4'h3);
    wait_ok(2);
    `CHK("resend", {11'h123, 1'b0, 4'h4, D1}, NODE.last_tx)
    ident(8'h01);
    `CHK("irq on", 1'b1, irq)
    wb(9'h000, 1'b0, 32'h0000_0000, 4'h1);
    ident(8'h01);
    wb(9'h000, 1'b0, 32'h0000_0000, 4'h3);
    st = q[15:8];
    `CHK("tx success", 1'b1, q[11])
    ident(8'h03);
    wb(9'h050, 1'b1, 32'h0000_FFFD, 4'h3);
    ident(8'h00);
    `CHK("irq off", 1'b0, irq)
    wb(9'h000, 1'b1, {16'h0000, st & 8'hF7, 8'h00}, 4'h2);
    wb(9'h000, 1'b0, 32'h0000_0000, 4'h2);
    `CHK("success clr", 1'b0, q[11])
    // Remote request from receive object 2, answer and overrun
    wb(9'h060, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("new data pre", 2'b01, q[9:8])
    wb(9'h060, 1'b1, 32'h0000_EFFF, 4'h3);
    wait_ok(3);
    `CHK("rid", 11'h2A5, NODE.last_tx.id)
    `CHK("rtr", 1'b1, NODE.last_tx.rtr)
    NODE.send({11'h2A5, 1'b0, 4'h3, 64'h0000_0000_00AA_BBCC});
    repeat (4) @(posedge mclk);
    wb(9'h060, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("new data", 32'h0000_0200, q & 32'h0000_0200)
    `CHK("rx ipnd", 2'b10, q[1:0])
    wb(9'h064, 1'b0, 32'h0000_0000, 4'hF);
    `CHK("dlc", 4'h3, q[15:12])
    NODE.send({11'h2A5, 1'b0, 4'h3, 64'h0000_0000_0000_0001});
    repeat (4) @(posedge mclk);
    wb(9'h060, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("lost", 2'b10, q[11:10])
    wb(9'h068, 1'b0, 32'h0000_0000, 4'hF);
    `CHK("rx data", 32'h00AA_BBCC, q)
    // Remote frame into object 1 held by cpu update, then answered
    wb(9'h050, 1'b1, 32'h0000_FBFF, 4'h3);
    NODE.send({11'h123, 1'b1, 4'h8, 64'hDEAD_BEEF_0000_0000});
    repeat (40) @(posedge mclk);
    wb(9'h050, 1'b0, 32'h0000_0000, 4'h3);
    `CHK("held", 4'b1010, q[15:12])
    `CHK("rmt ipnd", 2'b10, q[1:0])
    `CHK("no send", 3, NODE.n_ok)
    wb(9'h050, 1'b1, 32'h0000_F7FF, 4'h3);
    wait_ok(4);
    `CHK("answer", {11'h123, 1'b0, 4'h8, D1}, NODE.last_tx)
    // Priority walk down to empty
    ident(8'h01);
    wb(9'h000, 1'b0, 32'h0000_0000, 4'h2);
    ident(8'h03);
    wb(9'h050, 1'b1, 32'h0000_FFFD, 4'h3);
    ident(8'h04);
    wb(9'h050, 1'b1, 32'h0000_FFFE, 4'h3);
    ident(8'h03);
    wb(9'h050, 1'b1, 32'h0000_FFFD, 4'h3);
    wb(9'h060, 1'b1, 32'h0000_FFFD, 4'h3);
    ident(8'h00);
    stop_test();
  end
endmodule

bind moh_message_object_handler moh_message_object_handler_monitor #(
  .BIT_CYCLES(BIT_CYCLES), .IDLE_BITS(IDLE_BITS)) MON (.mclk, .nrst, .wb_adr_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .can_rx_pin, .bus_on, .tx_valid,
  .tx_frame, .tx_done, .irq);
